//--- logic/tas_pkg.sv
// Constants for the throttle alert status and pulse register block
package tas_pkg;

    // Byte locations of the 16-bit status and control register
    localparam logic [7:0] TAS_ADDR_LO = 8'h22;
    localparam logic [7:0] TAS_ADDR_HI = 8'h23;

    // Field positions within the high byte
    localparam int TAS_HI_RSVD7  = 7;
    localparam int TAS_HI_EXT_EN = 6;
    localparam int TAS_HI_WID_HI = 5;
    localparam int TAS_HI_WID_LO = 4;
    localparam int TAS_HI_RELEASE = 3;
    localparam int TAS_HI_RSVD2  = 2;
    localparam int TAS_HI_FAIL   = 1;
    localparam int TAS_HI_EXIT   = 0;

    // Trigger flag position that the host may write
    localparam int TAS_LO_DROOP = 7;

    // Values after reset (whole register reads 16'hA800)
    localparam logic [15:0] TAS_RESET_VALUE = 16'ha800;
    localparam logic [1:0]  TAS_WIDTH_RST   = 2'h2;
    localparam logic [7:0]  TAS_FLAGS_RST   = 8'h00;

    // Pulse width selector codes
    localparam logic [1:0] TAS_W_100US = 2'h0;
    localparam logic [1:0] TAS_W_1MS   = 2'h1;
    localparam logic [1:0] TAS_W_10MS  = 2'h2;
    localparam logic [1:0] TAS_W_5MS   = 2'h3;

    // Clock and minimum pulse times, in ns; least times round up
    localparam int TAS_CLK_PERIOD_NS = 20;
    localparam int TAS_T_100US_NS    = 100_000;
    localparam int TAS_T_1MS_NS      = 1_000_000;
    localparam int TAS_T_10MS_NS     = 10_000_000;
    localparam int TAS_T_5MS_NS      = 5_000_000;
    localparam int TAS_CYC_100US = (TAS_T_100US_NS + TAS_CLK_PERIOD_NS - 1) / TAS_CLK_PERIOD_NS;
    localparam int TAS_CYC_1MS   = (TAS_T_1MS_NS + TAS_CLK_PERIOD_NS - 1) / TAS_CLK_PERIOD_NS;
    localparam int TAS_CYC_10MS  = (TAS_T_10MS_NS + TAS_CLK_PERIOD_NS - 1) / TAS_CLK_PERIOD_NS;
    localparam int TAS_CYC_5MS   = (TAS_T_5MS_NS + TAS_CLK_PERIOD_NS - 1) / TAS_CLK_PERIOD_NS;
    localparam int TAS_CNT_W     = 20;

    // Consecutive load failures that latch assist mode off
    localparam logic [2:0] TAS_FAIL_LIMIT = 3'h7;

    // Alert pulse sequencer states
    typedef enum logic [2:0] {
        TAS_IDLE  = 3'b001,
        TAS_TIMED = 3'b010,
        TAS_HELD  = 3'b100
    } tas_state_t;

endpackage : tas_pkg

//--- logic/tas_throttle_alert.sv
// Throttle alert status register, pulse sequencer and alert pin driver
// Behaviour
// - Extension on: pin low until release
// - Extension off: pulse lasts selected minimum width
// - Release written 0 ends pulse, idle 1
// - Seven load failures latch assist off
// - Eight trigger flags; only droop host writable
// - Reset value A800h, reserved bits fixed
`timescale 1ns/1ps
`default_nettype none

module tas_throttle_alert
    import tas_pkg::*;
#(
    parameter logic [TAS_CNT_W-1:0] CYC_100US = TAS_CNT_W'(TAS_CYC_100US),
    parameter logic [TAS_CNT_W-1:0] CYC_1MS   = TAS_CNT_W'(TAS_CYC_1MS),
    parameter logic [TAS_CNT_W-1:0] CYC_10MS  = TAS_CNT_W'(TAS_CYC_10MS),
    parameter logic [TAS_CNT_W-1:0] CYC_5MS   = TAS_CNT_W'(TAS_CYC_5MS)
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       link_clk,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic       input_droop_cond,
    input  wire logic       comparator_cond,
    input  wire logic       critical_current_cond,
    input  wire logic       nominal_current_cond,
    input  wire logic       discharge_current_cond,
    input  wire logic       system_voltage_cond,
    input  wire logic       battery_removal_cond,
    input  wire logic       adapter_removal_cond,
    input  wire logic       input_cap_assist_mode,
    input  wire logic       assist_load_fail,
    input  wire logic       assist_load_ok,
    output logic            assist_mode_allowed,
    output logic            throttle_alert_pin_o,
    output logic            throttle_alert_pin_oe_n
);

    // Register state
    logic                 alert_pulse_extend_en_r;
    logic [1:0]           alert_min_pulse_width_r;
    logic                 alert_pulse_release_r;
    logic                 assist_fail_flag_r;
    logic                 assist_exit_flag_r;
    logic [7:0]           trig_flags_r;
    logic [7:0]           rdata_r;
    logic                 rvalid_r;

    // Condition synchronisers and edge history
    logic [7:0]           cond_s1_r;
    logic [7:0]           cond_s2_r;
    logic [7:0]           cond_prev_r;
    logic [7:0]           cond_raw;
    logic [7:0]           cond_rise;
    logic                 new_event;
    logic                 any_cond;

    // Assist tracking
    logic [2:0]           fail_cnt_r;
    logic                 assist_prev_r;
    logic                 fail_hit;
    logic                 exit_hit;
    logic                 allowed_r;

    // Pulse sequencer
    tas_state_t           state_r;
    tas_state_t           state_nxt;
    logic [TAS_CNT_W-1:0] cnt_r;
    logic                 pin_low_r;

    // Host accesses decoded
    logic                 wr_lo;
    logic                 wr_hi;
    logic                 rd_lo;
    logic                 release_req;

    // Link domain
    logic                 lk_rst_s1_r;
    logic                 lk_rst_s2_r;
    logic                 lk_en_s1_r;
    logic                 lk_en_s2_r;
    logic                 lk_low_s1_r;
    logic                 lk_low_s2_r;
    logic                 pin_oe_n_r;
    logic                 pin_o_r;

    // Width selector to minimum cycle count
    function automatic logic [TAS_CNT_W-1:0] width_cycles(input logic [1:0] sel);
        logic [TAS_CNT_W-1:0] c;
        c = CYC_10MS;
        case (sel)
            TAS_W_100US: c = CYC_100US;
            TAS_W_1MS:   c = CYC_1MS;
            TAS_W_10MS:  c = CYC_10MS;
            TAS_W_5MS:   c = CYC_5MS;
            default:     c = CYC_10MS;
        endcase
        return c;
    endfunction : width_cycles

    assign wr_lo = reg_wr && (reg_addr == TAS_ADDR_LO);
    assign wr_hi = reg_wr && (reg_addr == TAS_ADDR_HI);
    assign rd_lo = reg_rd && (reg_addr == TAS_ADDR_LO);
    assign release_req = wr_hi && !reg_wdata[TAS_HI_RELEASE];

    // Conditions arrive from analog comparators, bit order as the flag byte
    assign cond_raw = {input_droop_cond, comparator_cond, critical_current_cond,
                       nominal_current_cond, discharge_current_cond, system_voltage_cond,
                       battery_removal_cond, adapter_removal_cond};

    // Two-flop synchronisers; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cond_s1_r   <= 8'h00;
            cond_s2_r   <= 8'h00;
            cond_prev_r <= 8'h00;
        end else if (clk_en) begin
            cond_s1_r   <= cond_raw;
            cond_s2_r   <= cond_s1_r;
            cond_prev_r <= cond_s2_r;
        end
    end

    assign cond_rise = cond_s2_r & ~cond_prev_r;
    assign new_event = |cond_rise;
    assign any_cond  = |cond_s2_r;

    // trigger flags; set wins over read clear and droop write clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_flags_r <= TAS_FLAGS_RST;
        end else if (clk_en) begin
            if (rd_lo) begin
                trig_flags_r[TAS_LO_DROOP-1:0] <= cond_rise[TAS_LO_DROOP-1:0];
            end else begin
                trig_flags_r[TAS_LO_DROOP-1:0] <= trig_flags_r[TAS_LO_DROOP-1:0]
                                                  | cond_rise[TAS_LO_DROOP-1:0];
            end
            // Host may only clear droop; a written 1 must not fake a trigger
            if (cond_rise[TAS_LO_DROOP]) begin
                trig_flags_r[TAS_LO_DROOP] <= 1'b1;
            end else if (wr_lo && !reg_wdata[TAS_LO_DROOP]) begin
                trig_flags_r[TAS_LO_DROOP] <= 1'b0;
            end
        end
    end

    // control fields start at their power-on values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alert_pulse_extend_en_r <= TAS_RESET_VALUE[8 + TAS_HI_EXT_EN];
            alert_min_pulse_width_r <= TAS_WIDTH_RST;
        end else if (clk_en && wr_hi) begin
            alert_pulse_extend_en_r <= reg_wdata[TAS_HI_EXT_EN];
            alert_min_pulse_width_r <= reg_wdata[TAS_HI_WID_HI:TAS_HI_WID_LO];
        end
    end

    // release bit reads 0 for one cycle after the write, then idles at 1
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alert_pulse_release_r <= TAS_RESET_VALUE[8 + TAS_HI_RELEASE];
        end else if (clk_en) begin
            alert_pulse_release_r <= !release_req;
        end
    end

    // count consecutive load failures; a success restarts the run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fail_cnt_r <= 3'h0;
        end else if (clk_en) begin
            if (fail_hit || assist_load_ok || !input_cap_assist_mode) begin
                fail_cnt_r <= 3'h0;
            end else if (assist_load_fail) begin
                fail_cnt_r <= fail_cnt_r + 3'h1;
            end
        end
    end

    assign fail_hit = input_cap_assist_mode && assist_load_fail
                      && (fail_cnt_r == TAS_FAIL_LIMIT - 3'h1);

    // Falling assist mode means the charger left it, for whatever cause
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            assist_prev_r <= 1'b0;
        end else if (clk_en) begin
            assist_prev_r <= input_cap_assist_mode;
        end
    end

    assign exit_hit = (assist_prev_r && !input_cap_assist_mode) || fail_hit;

    // failure latch; set wins over a host clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            assist_fail_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (fail_hit) begin
                assist_fail_flag_r <= 1'b1;
            end else if (wr_hi && !reg_wdata[TAS_HI_FAIL]) begin
                assist_fail_flag_r <= 1'b0;
            end
        end
    end

    // exit latch; set wins over a host clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            assist_exit_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (exit_hit) begin
                assist_exit_flag_r <= 1'b1;
            end else if (wr_hi && !reg_wdata[TAS_HI_EXIT]) begin
                assist_exit_flag_r <= 1'b0;
            end
        end
    end

    // assist stays latched off while the failure flag stands
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            allowed_r <= 1'b1;
        end else if (clk_en) begin
            allowed_r <= !(fail_hit || (assist_fail_flag_r
                           && !(wr_hi && !reg_wdata[TAS_HI_FAIL])));
        end
    end

    // Pulse sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TAS_IDLE: begin
                if (new_event) begin
                    state_nxt = alert_pulse_extend_en_r ? TAS_HELD : TAS_TIMED;
                end
            end
            TAS_TIMED: begin
                if (new_event && alert_pulse_extend_en_r) begin
                    state_nxt = TAS_HELD;
                end else if (!new_event && cnt_r == '0 && !any_cond) begin
                    state_nxt = TAS_IDLE;
                end
            end
            TAS_HELD: begin
                // a fresh event in the release cycle keeps the pulse
                if (release_req && !new_event) begin
                    state_nxt = TAS_IDLE;
                end
            end
            default: state_nxt = TAS_IDLE;
        endcase
    end

    // held state waits only for the release write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= TAS_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // minimum width timer, restarted by every new event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            if (new_event) begin
                cnt_r <= width_cycles(alert_min_pulse_width_r) - TAS_CNT_W'(1);
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - TAS_CNT_W'(1);
            end
        end
    end

    // pin level combines pulse and exit hold
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_low_r <= 1'b0;
        end else if (clk_en) begin
            pin_low_r <= (state_nxt != TAS_IDLE) || assist_exit_flag_r || exit_hit;
        end
    end

    // read mux; reserved bits fixed, unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (clk_en) begin
            rvalid_r <= reg_rd;
            if (rd_lo) begin
                rdata_r <= trig_flags_r;
            end else if (reg_rd && reg_addr == TAS_ADDR_HI) begin
                rdata_r <= {TAS_RESET_VALUE[8 + TAS_HI_RSVD7], alert_pulse_extend_en_r,
                            alert_min_pulse_width_r, alert_pulse_release_r,
                            TAS_RESET_VALUE[8 + TAS_HI_RSVD2], assist_fail_flag_r,
                            assist_exit_flag_r};
            end else if (reg_rd) begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign reg_rdata           = rdata_r;
    assign reg_rvalid          = rvalid_r;
    assign assist_mode_allowed = allowed_r;

    // Link domain: reset and enable cross as levels through two flops
    always_ff @(posedge link_clk) begin
        lk_rst_s1_r <= rst_n;
        lk_rst_s2_r <= lk_rst_s1_r;
        lk_en_s1_r  <= clk_en;
        lk_en_s2_r  <= lk_en_s1_r;
    end

    // Alert level synchroniser into the link domain
    always_ff @(posedge link_clk) begin
        if (!lk_rst_s2_r) begin
            lk_low_s1_r <= 1'b0;
            lk_low_s2_r <= 1'b0;
        end else if (lk_en_s2_r) begin
            lk_low_s1_r <= pin_low_r;
            lk_low_s2_r <= lk_low_s1_r;
        end
    end

    // Open-drain driver; pin only ever pulled low, released otherwise
    always_ff @(posedge link_clk) begin
        if (!lk_rst_s2_r) begin
            pin_oe_n_r <= 1'b1;
            pin_o_r    <= 1'b0;
        end else if (lk_en_s2_r) begin
            pin_oe_n_r <= !lk_low_s2_r;
            pin_o_r    <= 1'b0;
        end
    end

    assign throttle_alert_pin_o    = pin_o_r;
    assign throttle_alert_pin_oe_n = pin_oe_n_r;

endmodule : tas_throttle_alert

`default_nettype wire

//--- test/tas_cpu_model.sv
// Processor end of the open-drain throttle alert line
`timescale 1ns/1ps
`default_nettype none
module tas_cpu_model (
    input  wire logic        throttle_alert_pin_o,
    input  wire logic        throttle_alert_pin_oe_n,
    output logic             alert_wire,
    output logic [31:0]      low_ns
);
    realtime fall_t;
    // Pull-up wins whenever the driver lets go, unknown enable too
    assign alert_wire = (throttle_alert_pin_oe_n === 1'b0) ? throttle_alert_pin_o : 1'b1;
    // Low pulse width as the processor measures it
    initial begin
        low_ns = 32'h0000_0000;
        fall_t = 0.0;
    end
    always @(negedge alert_wire) fall_t = $realtime;
    always @(posedge alert_wire) low_ns = 32'($rtoi($realtime - fall_t));
endmodule : tas_cpu_model
`default_nettype wire

//--- test/tas_throttle_alert_props.sv
// Port checker for the throttle alert register block
`timescale 1ns/1ps
`default_nettype none
module tas_throttle_alert_props
    import tas_pkg::*;
#(
    parameter logic [TAS_CNT_W-1:0] CYC_100US = 20'h0_000a
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       input_droop_cond,
    input wire logic       input_cap_assist_mode,
    input wire logic       assist_load_fail,
    input wire logic       assist_mode_allowed,
    input wire logic       throttle_alert_pin_oe_n
);
    logic        ext_r;
    logic [7:0]  rel_age_r;
    logic [19:0] low_cnt_r;
    wire logic   hi_wr = clk_en && reg_wr && reg_addr == TAS_ADDR_HI;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Shadow of extension enable and age of last release write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_r     <= 1'b0;
            rel_age_r <= 8'hff;
        end else begin
            if (hi_wr) ext_r <= reg_wdata[TAS_HI_EXT_EN];
            if (hi_wr && !reg_wdata[TAS_HI_RELEASE]) rel_age_r <= 8'h00;
            else if (rel_age_r != 8'hff) rel_age_r <= rel_age_r + 8'h01;
        end
    end
    // Length of the current low pulse, in main clocks
    always_ff @(posedge clk) begin
        if (!rst_n || throttle_alert_pin_oe_n) low_cnt_r <= 20'h0_0000;
        else low_cnt_r <= low_cnt_r + 20'h0_0001;
    end
    rd_answer_a: assert property (clk_en && reg_rd |=> reg_rvalid)
        else $error("read strobe got no valid");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(clk_en && reg_rd))
        else $error("valid without read strobe");
    rsvd_bits_a: assert property (clk_en && reg_rd && reg_addr == TAS_ADDR_HI
        |=> reg_rdata[TAS_HI_RSVD7] && !reg_rdata[TAS_HI_RSVD2]) else $error("reserved bits wrong");
    unmapped_zero_a: assert property (clk_en && reg_rd && reg_addr != TAS_ADDR_LO
        && reg_addr != TAS_ADDR_HI |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    fail_cause_a: assert property ($fell(assist_mode_allowed)
        |-> $past(assist_load_fail) && $past(input_cap_assist_mode)) else $error("latch without fail");
    droop_alert_a: assert property ($rose(input_droop_cond)
        |-> ##[1:14] !throttle_alert_pin_oe_n) else $error("droop gave no alert");
    exit_alert_a: assert property ($fell(input_cap_assist_mode)
        |-> ##[1:14] !throttle_alert_pin_oe_n) else $error("assist exit gave no alert");
    ext_hold_a: assert property (ext_r && $rose(throttle_alert_pin_oe_n)
        |-> rel_age_r < 8'h14) else $error("extended pulse ended without release");
    min_width_a: assert property (!ext_r && $rose(throttle_alert_pin_oe_n)
        |-> low_cnt_r >= CYC_100US - 20'h0_0002) else $error("alert pulse too short");
    cover property (ext_r && $rose(throttle_alert_pin_oe_n));
    cover property ($fell(assist_mode_allowed));
    cover property (clk_en && reg_rd && reg_addr == TAS_ADDR_LO);
endmodule : tas_throttle_alert_props
bind tas_throttle_alert tas_throttle_alert_props #(.CYC_100US(CYC_100US)) u_props (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .input_droop_cond(input_droop_cond), .input_cap_assist_mode(input_cap_assist_mode),
    .assist_load_fail(assist_load_fail), .assist_mode_allowed(assist_mode_allowed),
    .throttle_alert_pin_oe_n(throttle_alert_pin_oe_n));
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the throttle alert register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tas_pkg::*;
    logic        clk, rst_n, link_clk, reg_wr, reg_rd, mode, lfail, lok, en;
    logic        rvalid, allowed, pin_o, pin_oe_n, alert_wire;
    logic [7:0]  reg_addr, reg_wdata, cond, rdata, got;
    logic [1:0]  w;
    logic [31:0] low_ns;
    int          err_total, compares, i;
    tas_throttle_alert #(.CYC_100US(20'h0_000a), .CYC_1MS(20'h0_0014),
        .CYC_10MS(20'h0_0028), .CYC_5MS(20'h0_001e)) u_tas_throttle_alert (
        .clk(clk), .rst_n(rst_n), .clk_en(en), .link_clk(link_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .input_droop_cond(cond[7]), .comparator_cond(cond[6]),
        .critical_current_cond(cond[5]), .nominal_current_cond(cond[4]),
        .discharge_current_cond(cond[3]), .system_voltage_cond(cond[2]),
        .battery_removal_cond(cond[1]), .adapter_removal_cond(cond[0]),
        .input_cap_assist_mode(mode), .assist_load_fail(lfail), .assist_load_ok(lok),
        .assist_mode_allowed(allowed), .throttle_alert_pin_o(pin_o),
        .throttle_alert_pin_oe_n(pin_oe_n));
    tas_cpu_model u_tas_cpu_model (.throttle_alert_pin_o(pin_o),
        .throttle_alert_pin_oe_n(pin_oe_n), .alert_wire(alert_wire), .low_ns(low_ns));
    // Main and link clocks, unrelated in phase
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Minimum width in cycles per selector code
    function automatic int exp_cycles(input logic [1:0] code);
        case (code)
            2'h0: return 10;
            2'h1: return 20;
            2'h2: return 40;
            default: return 30;
        endcase
    endfunction : exp_cycles
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_byte
    task automatic check_bit(input string what, input logic exp, input logic seen);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check_bit("read valid", 1'b1, rvalid);
        d = rdata;
    endtask : reg_read
    // Bounded wait for the alert line to reach a level
    task automatic wait_pin(input logic lvl, input int max);
        for (int n = 0; n < max && alert_wire !== lvl; n++) @(negedge clk);
        check_bit("alert line", lvl, alert_wire);
    endtask : wait_pin
    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        // About fifteen times the expected run length
        #200_000;
        err_total++;
        $display("ERROR watchdog expected done seen hang");
        final_report();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, mode, lfail, lok, cond, reg_addr, reg_wdata} = '0;
        en = 1'b1;
        i = $urandom(32'h0000_b468);
        // Held past the link synchronisers, longer than two cycles
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        reg_read(TAS_ADDR_HI, got);
        check_byte("control at reset", 8'ha8, got);
        reg_write(TAS_ADDR_LO, 8'hff);
        reg_read(TAS_ADDR_LO, got);
        check_byte("flags at reset", 8'h00, got);
        reg_write(TAS_ADDR_HI, 8'hff);
        reg_write(8'h24, 8'h00);
        reg_read(8'h24, got);
        check_byte("unmapped read", 8'h00, got);
        reg_read(TAS_ADDR_HI, got);
        check_byte("control all ones", 8'hf8, got);
        // Every trigger, every width code, random hold
        for (i = 0; i < 8; i++) begin
            w = 2'(i % 4);
            reg_write(TAS_ADDR_HI, {2'b00, w, 4'h8});
            cond[7-i] = 1'b1;
            repeat (1 + $urandom % 4) @(negedge clk);
            cond[7-i] = 1'b0;
            wait_pin(1'b0, 20);
            wait_pin(1'b1, 200);
            check_bit("pulse width", 1'b1, low_ns >= 32'((exp_cycles(w) - 2) * 20));
            reg_read(TAS_ADDR_LO, got);
            check_byte("trigger flag", 8'h80 >> i, got);
            reg_write(TAS_ADDR_LO, 8'h00);
            reg_read(TAS_ADDR_LO, got);
            check_byte("flags cleared", 8'h00, got);
        end
        // Extended pulse ends only on release
        reg_write(TAS_ADDR_HI, 8'h68);
        cond[6] = 1'b1;
        repeat (3) @(negedge clk);
        cond[6] = 1'b0;
        repeat (120) @(negedge clk);
        check_bit("extended low", 1'b0, alert_wire);
        reg_write(TAS_ADDR_HI, 8'h60);
        wait_pin(1'b1, 20);
        reg_read(TAS_ADDR_HI, got);
        check_byte("release idle", 8'he8, got);
        reg_read(TAS_ADDR_LO, got);
        // Six fails, restart, then seven fails latch
        reg_write(TAS_ADDR_HI, 8'h28);
        mode = 1'b1;
        for (i = 0; i < 14; i++) begin
            @(negedge clk);
            if (i == 13) check_bit("allowed after restart", 1'b1, allowed);
            lok = (i == 6);
            lfail = (i != 6);
        end
        @(negedge clk);
        {lfail, lok, mode} = 3'b000;
        check_bit("assist latched off", 1'b0, allowed);
        wait_pin(1'b0, 20);
        reg_read(TAS_ADDR_HI, got);
        check_byte("fail and exit", 8'hab, got);
        reg_write(TAS_ADDR_HI, 8'h28);
        check_bit("assist allowed again", 1'b1, allowed);
        wait_pin(1'b1, 200);
        // Plain exit holds the line until cleared
        mode = 1'b1;
        repeat (4) @(negedge clk);
        mode = 1'b0;
        repeat (120) @(negedge clk);
        check_bit("exit holds low", 1'b0, alert_wire);
        reg_read(TAS_ADDR_HI, got);
        check_byte("exit flag", 8'ha9, got);
        reg_write(TAS_ADDR_HI, 8'h28);
        wait_pin(1'b1, 200);
        // Enable low freezes the register against a write
        en = 1'b0;
        reg_write(TAS_ADDR_HI, 8'h58);
        en = 1'b1;
        reg_read(TAS_ADDR_HI, got);
        check_byte("frozen write", 8'ha8, got);
        final_report();
    end
endmodule : testbench
`default_nettype wire
